/* File: rtl/srap_spi_port.sv */
// Serial register access port: four-pin serial slave in front of a
// buffered register map, with I/O update and readback source selection.
// Assumes pins arrive asynchronous to clock and that the serial clock runs
// at well under a quarter of the system clock rate.
//
// Summary of operation
// - 3-wire and 4-wire, both bit orders; reset is bidirectional MSB first.
// - A cycle starts when chip select goes low; sampling only while low.
// - Up to three payload bytes: chip select may pause on byte boundaries.
// - During a stall the port waits; a later rise after a partial byte, or after the last owed byte, returns it to idle.
// - Chip select rising off a byte boundary discards data and returns idle.
// - Streaming moves any number of bytes; chip select rise ends it.
// - Count field 00,01,10 gives one to three bytes; 11 streams.
// - Instruction is 16 bits: read flag, two count bits, 13 address bits.
// - Instruction and write data are taken on rising serial clock edges.
// - Non-stream writes stall after whole bytes; last byte ends the cycle.
// - Reserved and unmapped addresses are never skipped.
// - Writes go to buffers; update bit 0 at 0x0005 or pin applies them.
// - Reads shift out N bytes, bits changing on falling serial clock edges.
// - Readback source is buffer or active registers per bit 0 at 0x0004.
// - Bit 6 of port configuration selects LSB first from the next operation.
// - MSB first names highest address and the address decrements.
// - LSB first names lowest address and the address increments.
// - Both data outputs float while chip select is high.
// - Port configuration lives in the port and is never forwarded.
`timescale 1ns/1ps

module srap_spi_port (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               sclk_pin,
  input  wire logic               cs_n_pin,
  input  wire logic               sdio_in,
  output logic                    sdio_out,
  output logic                    sdio_oe,
  output logic                    serial_data_out_pin,
  output logic                    serial_data_out_pin_oe,
  input  wire logic               io_update_pin,
  input  wire logic [7:0]         buf_rdata,
  input  wire logic [7:0]         act_rdata,
  output logic [12:0]             reg_addr,
  output srap_pkg::srap_wr_t      reg_wr,
  output logic                    reg_we,
  output logic                    io_update,
  output logic [7:0]              port_cfg
);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Pin synchronisers and edge finders
  // The link clock is only sampled, so edges are found two system clocks
  // late; all inputs share one delay and keep their mutual alignment.
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= srap_pkg::SRAP_SYNC_RST;
      s2_q <= srap_pkg::SRAP_SYNC_RST;
      s3_q <= srap_pkg::SRAP_SYNC_RST;
    end else begin
      s1_q <= {io_update_pin, sdio_in, cs_n_pin, sclk_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_s;
  logic cs_rise;
  logic din;
  logic upd_rise;

  assign sclk_rise = s2_q[0] & ~s3_q[0];
  assign sclk_fall = ~s2_q[0] & s3_q[0];
  assign cs_s      = s2_q[1];
  assign cs_rise   = s2_q[1] & ~s3_q[1];
  assign din       = s2_q[2];
  assign upd_rise  = s2_q[3] & ~s3_q[3];

  // ==========================================================================
  // Transfer state
  srap_pkg::srap_state_t state_q;
  logic [3:0]            cnt_q;
  logic [15:0]           ish_q;
  logic [7:0]            wsh_q;
  logic [12:0]           addr_q;
  logic                  rd_q;
  logic                  stream_q;
  logic                  done_q;
  logic [1:0]            left_q;
  logic                  lsb_act_q;
  logic                  four_act_q;
  logic [7:0]            cfg_q;
  logic                  rbsel_q;

  logic [15:0]           ish_d;
  logic [7:0]            wsh_d;
  srap_pkg::srap_instr_t ins;
  logic                  instr_end;
  logic                  byte_end;
  logic                  wr_fire;
  logic [12:0]           addr_step;

  // Bit order is fixed for the whole cycle so that a mid-cycle write of
  // the order bit cannot scramble the bytes still to come.
  assign ish_d = lsb_act_q ? {din, ish_q[15:1]} : {ish_q[14:0], din};
  assign wsh_d = lsb_act_q ? {din, wsh_q[7:1]} : {wsh_q[6:0], din};
  assign ins   = srap_pkg::srap_instr_t'(ish_d);

  assign instr_end = (state_q == srap_pkg::SRAP_ST_INSTR) && !cs_s &&
                     sclk_rise && (cnt_q == srap_pkg::SRAP_LAST_INSTR);
  assign byte_end  = (state_q == srap_pkg::SRAP_ST_DATA) && !cs_s &&
                     sclk_rise && !done_q &&
                     (cnt_q[2:0] == srap_pkg::SRAP_LAST_BIT);
  assign wr_fire   = byte_end && !rd_q;
  // Every address is visited in turn, reserved or not.
  assign addr_step = lsb_act_q ? addr_q + 13'h0001 : addr_q - 13'h0001;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= srap_pkg::SRAP_ST_IDLE;
      cnt_q      <= 4'h0;
      ish_q      <= 16'h0000;
      wsh_q      <= 8'h00;
      addr_q     <= 13'h0000;
      rd_q       <= 1'b0;
      stream_q   <= 1'b0;
      done_q     <= 1'b0;
      left_q     <= 2'h0;
      lsb_act_q  <= 1'b0;
      four_act_q <= 1'b0;
    end else begin
      case (state_q)
        srap_pkg::SRAP_ST_IDLE: begin
          if (!cs_s) begin
            state_q    <= srap_pkg::SRAP_ST_INSTR;
            cnt_q      <= 4'h0;
            lsb_act_q  <= cfg_q[srap_pkg::SRAP_CFG_LSB_BIT];
            four_act_q <= cfg_q[srap_pkg::SRAP_CFG_4W_BIT];
          end
        end
        srap_pkg::SRAP_ST_INSTR: begin
          if (cs_rise) begin
            if ((cnt_q[2:0] != 3'h0) || (cnt_q == 4'h0)) begin
              state_q <= srap_pkg::SRAP_ST_IDLE;
            end
          end else if (!cs_s && sclk_rise) begin
            ish_q <= ish_d;
            cnt_q <= cnt_q + 4'h1;
            if (instr_end) begin
              state_q  <= srap_pkg::SRAP_ST_DATA;
              cnt_q    <= 4'h0;
              rd_q     <= ins.rd;
              stream_q <= (ins.cnt == srap_pkg::SRAP_CNT_STREAM);
              left_q   <= (ins.cnt == srap_pkg::SRAP_CNT_STREAM) ?
                          2'h0 : ins.cnt;
              addr_q   <= ins.addr;
              done_q   <= 1'b0;
            end
          end
        end
        srap_pkg::SRAP_ST_DATA: begin
          if (cs_rise) begin
            // A rise on a boundary with bytes still owed is a stall.
            if ((cnt_q[2:0] != 3'h0) || stream_q || done_q) begin
              state_q <= srap_pkg::SRAP_ST_IDLE;
            end
          end else if (!cs_s && sclk_rise && !done_q) begin
            wsh_q <= wsh_d;
            cnt_q <= {1'b0, cnt_q[2:0] + 3'h1};
            if (byte_end) begin
              cnt_q  <= 4'h0;
              addr_q <= addr_step;
              if (!stream_q) begin
                if (left_q == 2'h0) begin
                  done_q <= 1'b1;
                end else begin
                  left_q <= left_q - 2'h1;
                end
              end
            end
          end
        end
        default: begin
          state_q <= srap_pkg::SRAP_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Port-local registers and write forwarding
  // The configuration register never reaches the map, so a fault in the map
  // or its loader cannot lock software out of the port.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q   <= srap_pkg::SRAP_CFG_RST;
      rbsel_q <= srap_pkg::SRAP_RBSEL_RST;
    end else if (wr_fire) begin
      if (addr_q == srap_pkg::SRAP_ADDR_CFG) begin
        cfg_q <= wsh_d;
      end
      if (addr_q == srap_pkg::SRAP_ADDR_RBSEL) begin
        rbsel_q <= wsh_d[srap_pkg::SRAP_RBSEL_BIT];
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_we    <= 1'b0;
      reg_wr    <= '0;
      io_update <= 1'b0;
    end else begin
      reg_we    <= wr_fire && (addr_q != srap_pkg::SRAP_ADDR_CFG) &&
                   (addr_q != srap_pkg::SRAP_ADDR_UPDATE);
      if (wr_fire) begin
        reg_wr <= '{addr: addr_q, data: wsh_d};
      end
      io_update <= (wr_fire && (addr_q == srap_pkg::SRAP_ADDR_UPDATE) &&
                    wsh_d[srap_pkg::SRAP_UPDATE_BIT]) || upd_rise;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_addr <= 13'h0000;
      port_cfg <= srap_pkg::SRAP_CFG_RST;
    end else begin
      reg_addr <= addr_q;
      port_cfg <= cfg_q;
    end
  end

  // ==========================================================================
  // Read path
  logic [7:0] rdata;
  logic [7:0] tx_q;
  logic       rd_drive;

  always_comb begin
    if (addr_q == srap_pkg::SRAP_ADDR_CFG) begin
      rdata = cfg_q;
    end else if (rbsel_q) begin
      rdata = act_rdata;
    end else begin
      rdata = buf_rdata;
    end
  end

  assign rd_drive = !cs_s && rd_q && (state_q == srap_pkg::SRAP_ST_DATA);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_q                <= 8'h00;
      sdio_out            <= 1'b0;
      serial_data_out_pin <= 1'b0;
    end else if (rd_drive && sclk_fall && !done_q) begin
      if (cnt_q[2:0] == 3'h0) begin
        tx_q                <= lsb_act_q ? {1'b0, rdata[7:1]} :
                                           {rdata[6:0], 1'b0};
        sdio_out            <= lsb_act_q ? rdata[0] : rdata[7];
        serial_data_out_pin <= lsb_act_q ? rdata[0] : rdata[7];
      end else begin
        tx_q                <= lsb_act_q ? {1'b0, tx_q[7:1]} :
                                           {tx_q[6:0], 1'b0};
        sdio_out            <= lsb_act_q ? tx_q[0] : tx_q[7];
        serial_data_out_pin <= lsb_act_q ? tx_q[0] : tx_q[7];
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sdio_oe                <= 1'b0;
      serial_data_out_pin_oe <= 1'b0;
    end else begin
      sdio_oe                <= rd_drive && !four_act_q;
      serial_data_out_pin_oe <= rd_drive && four_act_q;
    end
  end

  // ==========================================================================
  // Checks
  chk_float_when_high: assert property (
    cs_s |=> !sdio_oe && !serial_data_out_pin_oe)
    else $error("data outputs driven while deselected");

  chk_partial_abort: assert property (
    cs_rise && (state_q != srap_pkg::SRAP_ST_IDLE) && (cnt_q[2:0] != 3'h0)
    |=> state_q == srap_pkg::SRAP_ST_IDLE)
    else $error("partial byte did not return port to idle");

  chk_stall_hold: assert property (
    cs_rise && (state_q == srap_pkg::SRAP_ST_INSTR) && (cnt_q == 4'h8)
    |=> (state_q == srap_pkg::SRAP_ST_INSTR) && (cnt_q == 4'h8))
    else $error("stall on byte boundary lost the transfer");

  chk_update_pulse: assert property (
    wr_fire && (addr_q == srap_pkg::SRAP_ADDR_UPDATE) &&
    wsh_d[srap_pkg::SRAP_UPDATE_BIT]
    |=> io_update && !reg_we ##1 !io_update || $past(upd_rise))
    else $error("update write did not give one pulse");

  chk_addr_down: assert property (
    byte_end && !lsb_act_q |=> addr_q == $past(addr_q) - 13'h0001)
    else $error("address did not decrement in MSB-first order");

  chk_addr_up: assert property (
    byte_end && lsb_act_q |=> addr_q == $past(addr_q) + 13'h0001)
    else $error("address did not increment in LSB-first order");

  chk_count_one: assert property (
    instr_end && (ins.cnt == srap_pkg::SRAP_CNT_ONE)
    |=> !stream_q && (left_q == 2'h0) && !done_q)
    else $error("count code 00 not decoded as one byte");

  chk_idle_wait: assert property (
    (state_q == srap_pkg::SRAP_ST_IDLE) && cs_s
    |=> state_q == srap_pkg::SRAP_ST_IDLE)
    else $error("port left idle while deselected");

  chk_cfg_private: assert property (
    reg_we |-> reg_wr.addr != srap_pkg::SRAP_ADDR_CFG)
    else $error("configuration write forwarded to the map");

  chk_order_fixed: assert property (
    (state_q != srap_pkg::SRAP_ST_IDLE) ##1
    (state_q != srap_pkg::SRAP_ST_IDLE) |-> $stable(lsb_act_q))
    else $error("bit order changed inside a cycle");

  chk_drive_read_only: assert property (
    sdio_oe |-> $past(rd_q) && $past(state_q == srap_pkg::SRAP_ST_DATA))
    else $error("data pin driven outside a read payload");

endmodule

/* File: rtl/srap_pkg.sv */
// Package for the serial register access port.
// Assumes a single 50 MHz system clock shared by every user of these names.
package srap_pkg;

  // ==========================================================================
  // Widths and counts
  localparam int unsigned SRAP_ADDR_W        = 13;
  localparam int unsigned SRAP_INSTR_W       = 16;
  localparam int unsigned SRAP_BYTE_W        = 8;
  localparam logic [3:0]  SRAP_LAST_INSTR    = 4'hf;
  localparam logic [2:0]  SRAP_LAST_BIT      = 3'h7;

  // ==========================================================================
  // Addresses handled inside the port
  localparam logic [12:0] SRAP_ADDR_CFG      = 13'h0000;
  localparam logic [12:0] SRAP_ADDR_RBSEL    = 13'h0004;
  localparam logic [12:0] SRAP_ADDR_UPDATE   = 13'h0005;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned SRAP_CFG_LSB_BIT   = 6;
  localparam int unsigned SRAP_CFG_4W_BIT    = 7;
  localparam int unsigned SRAP_RBSEL_BIT     = 0;
  localparam int unsigned SRAP_UPDATE_BIT    = 0;
  localparam logic [7:0]  SRAP_CFG_RST       = 8'h00;
  localparam logic        SRAP_RBSEL_RST     = 1'b0;
  localparam logic [3:0]  SRAP_SYNC_RST      = 4'h2;

  // ==========================================================================
  // Byte count codes
  localparam logic [1:0]  SRAP_CNT_ONE       = 2'h0;
  localparam logic [1:0]  SRAP_CNT_STREAM    = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    SRAP_ST_IDLE,
    SRAP_ST_INSTR,
    SRAP_ST_DATA
  } srap_state_t;

  typedef struct packed {
    logic        rd;
    logic [1:0]  cnt;
    logic [12:0] addr;
  } srap_instr_t;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  data;
  } srap_wr_t;

endpackage

/* File: verif/srap_master_model.sv */
// ==========================================================================
// Controller model for the serial register access port.
// Assumes a 50 MHz bench clock; serial clock is 160 ns, still between frames.
`timescale 1ns/1ps

module srap_master_model (
  input  wire logic clock,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdio_d,
  output logic      sdio_d_oe,
  input  wire logic sdio_w,
  input  wire logic dout_w
);
  logic lsb_first;
  logic four_wire;
  logic split;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio_d = 1'b0;
    sdio_d_oe = 1'b0;
    lsb_first = 1'b0;
    four_wire = 1'b0;
    split = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge clock);
  endtask

  // Data changes while the clock is low; read data is taken just before the
  // next falling edge, the last moment the device must still hold it.
  task automatic bits(input int n, input logic [7:0] v,
                      output logic [7:0] r);
    int k;
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      k = lsb_first ? i : 7 - i;
      sdio_d = v[k];
      sclk = 1'b0;
      half();
      sclk = 1'b1;
      half();
      r[k] = four_wire ? dout_w : sdio_w;
    end
  endtask

  task automatic start();
    cs_n = 1'b0;
    half();
  endtask

  // Raised only after whole bytes unless a scenario aborts on purpose.
  task automatic stop();
    half();
    cs_n = 1'b1;
    sclk = 1'b0;
    repeat (8) @(negedge clock);
  endtask

  task automatic instr(input logic rd, input logic [1:0] c,
                       input logic [12:0] a);
    logic [15:0] w;
    logic [7:0]  r;
    w = {rd, c, a};
    sdio_d_oe = 1'b1;
    bits(8, lsb_first ? w[7:0] : w[15:8], r);
    if (split) begin
      stop();
      start();
    end
    bits(8, lsb_first ? w[15:8] : w[7:0], r);
    sdio_d_oe = !rd;
  endtask
  // Streams only through mapped bench locations, never long reserved runs.
endmodule

/* File: verif/test_spi_register_access_port.sv */
// ==========================================================================
// Self-checking bench for the serial register access port.
// Assumes the controller model and a small bench register map behind it.
`timescale 1ns/1ps

module test_spi_register_access_port;
  logic                clock;
  logic                sys_rst;
  logic                sclk;
  logic                cs_n;
  logic                sdio_d;
  logic                sdio_d_oe;
  logic                sdio_w;
  logic                dout_w;
  logic                sdio_out;
  logic                sdio_oe;
  logic                dout;
  logic                dout_oe;
  logic                io_update_pin;
  logic [7:0]          buf_rdata;
  logic [7:0]          act_rdata;
  logic [12:0]         reg_addr;
  srap_pkg::srap_wr_t  reg_wr;
  logic                reg_we;
  logic                io_update;
  logic [7:0]          port_cfg;
  logic [7:0]          bufm [64];
  logic [7:0]          actm [64];
  logic [7:0]          wd [4];
  logic [7:0]          rb [4];
  logic [7:0]          r;
  int                  we_cnt;
  int                  upd_cnt;
  int                  we0;
  int                  miscompares;
  int                  comparisons;

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // A released data line shows the inverse of its last value, not a hold.
  always_comb begin
    buf_rdata = bufm[reg_addr[5:0]];
    act_rdata = actm[reg_addr[5:0]];
    sdio_w = sdio_oe ? sdio_out : (sdio_d_oe ? sdio_d : ~sdio_out);
    dout_w = dout_oe ? dout : ~dout;
  end

  always @(posedge clock) begin
    if (reg_we) begin
      bufm[reg_wr.addr[5:0]] <= reg_wr.data;
      we_cnt <= we_cnt + 1;
    end
    if (io_update) begin
      upd_cnt <= upd_cnt + 1;
      for (int i = 0; i < 64; i++) actm[i] <= bufm[i];
    end
  end

  srap_master_model u_m (
    .clock     (clock),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .sdio_d    (sdio_d),
    .sdio_d_oe (sdio_d_oe),
    .sdio_w    (sdio_w),
    .dout_w    (dout_w)
  );

  srap_spi_port u_dut (
    .clock                  (clock),
    .sys_rst                (sys_rst),
    .sclk_pin               (sclk),
    .cs_n_pin               (cs_n),
    .sdio_in                (sdio_w),
    .sdio_out               (sdio_out),
    .sdio_oe                (sdio_oe),
    .serial_data_out_pin    (dout),
    .serial_data_out_pin_oe (dout_oe),
    .io_update_pin          (io_update_pin),
    .buf_rdata              (buf_rdata),
    .act_rdata              (act_rdata),
    .reg_addr               (reg_addr),
    .reg_wr                 (reg_wr),
    .reg_we                 (reg_we),
    .io_update              (io_update),
    .port_cfg               (port_cfg)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [1:0] c, input logic [12:0] a,
                    input int n, input logic stall);
    u_m.start();
    u_m.instr(1'b0, c, a);
    for (int i = 0; i < n; i++) begin
      if (stall) begin
        u_m.stop();
        u_m.start();
      end
      u_m.bits(8, wd[i], r);
    end
    u_m.stop();
  endtask

  task automatic rd(input logic [1:0] c, input logic [12:0] a, input int n);
    u_m.start();
    u_m.instr(1'b1, c, a);
    for (int i = 0; i < n; i++) begin
      u_m.bits(8, 8'h00, r);
      rb[i] = r;
    end
    chk(sdio_oe, !u_m.four_wire);
    chk(dout_oe, u_m.four_wire);
    u_m.stop();
    chk(sdio_oe | dout_oe, 1'b0);
  endtask

  task automatic pin_update();
    io_update_pin = 1'b1;
    repeat (8) @(negedge clock);
    io_update_pin = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  initial begin
    #400000;
    miscompares++;
    stop_test();
  end

  initial begin
    sys_rst = 1'b1;
    io_update_pin = 1'b0;
    we_cnt = 0;
    upd_cnt = 0;
    miscompares = 0;
    comparisons = 0;
    for (int i = 0; i < 64; i++) bufm[i] = 8'h00;
    for (int i = 0; i < 64; i++) actm[i] = 8'h00;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    chk(port_cfg, 8'h00);
    chk(sdio_oe | dout_oe, 1'b0);
    $display("test reset done");
    wd = '{8'ha1, 8'hb2, 8'hc3, 8'h00};
    u_m.split = 1'b1;
    wr(2'h2, 13'h0012, 3, 1'b1);
    u_m.split = 1'b0;
    chk(bufm[18], 8'ha1);
    chk(bufm[17], 8'hb2);
    chk(bufm[16], 8'hc3);
    chk(we_cnt, 3);
    $display("test stalled write done");
    rd(2'h1, 13'h0012, 2);
    chk(rb[0], 8'ha1);
    chk(rb[1], 8'hb2);
    $display("test read done");
    wd[0] = 8'h01;
    wr(2'h0, 13'h0004, 1, 1'b0);
    wr(2'h0, 13'h0005, 1, 1'b0);
    chk(upd_cnt, 1);
    chk(we_cnt, 4);
    wd[0] = 8'h55;
    wr(2'h0, 13'h0012, 1, 1'b0);
    rd(2'h0, 13'h0012, 1);
    chk(rb[0], 8'ha1);
    pin_update();
    chk(upd_cnt, 2);
    rd(2'h0, 13'h0012, 1);
    chk(rb[0], 8'h55);
    $display("test update done");
    we0 = we_cnt;
    u_m.start();
    u_m.instr(1'b0, 2'h2, 13'h0008);
    u_m.stop();
    u_m.start();
    u_m.bits(3, 8'hff, r);
    u_m.stop();
    chk(we_cnt, we0);
    wd[0] = 8'h77;
    wr(2'h0, 13'h0008, 1, 1'b0);
    chk(bufm[8], 8'h77);
    chk(reg_addr, 13'h0007);
    $display("test abort done");
    wd = '{8'h11, 8'h22, 8'h33, 8'h44};
    wr(2'h3, 13'h0022, 4, 1'b0);
    for (int i = 0; i < 4; i++) chk(bufm[34 - i], wd[i]);
    $display("test stream done");
    we0 = we_cnt;
    wd[0] = 8'h40;
    wr(2'h0, 13'h0000, 1, 1'b0);
    chk(port_cfg, 8'h40);
    chk(we_cnt, we0);
    u_m.lsb_first = 1'b1;
    wd = '{8'h91, 8'h92, 8'h00, 8'h00};
    wr(2'h1, 13'h0030, 2, 1'b0);
    chk(bufm[48], 8'h91);
    chk(bufm[49], 8'h92);
    wd[0] = 8'hc0;
    wr(2'h0, 13'h0000, 1, 1'b0);
    pin_update();
    u_m.four_wire = 1'b1;
    rd(2'h1, 13'h0030, 2);
    chk(rb[0], 8'h91);
    chk(rb[1], 8'h92);
    $display("test order and wiring done");
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    chk(port_cfg, 8'h00);
    u_m.lsb_first = 1'b0;
    u_m.four_wire = 1'b0;
    rd(2'h0, 13'h0000, 1);
    chk(rb[0], 8'h00);
    $display("test second reset done");
    stop_test();
  end
endmodule
